// ---- core/adcc_control.sv ----
// Command decoder and scan sequencer for the converter command control.
`timescale 1ns/10ps
`include "adcc_defs.svh"
module adcc_control
   import adcc_pkg::*;
#(
   parameter int          NUM_CH    = 16,
   parameter int          GPIO_BYTES = 2,
   parameter logic [11:0] TEMP_OFFSET = `ADCC_TEMP_OFFSET
) (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Serial port pins and start pin.
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        mosi,
   input  wire logic        conversion_start_pin_n,
   // Analog front end stand-in.
   input  wire logic [11:0] adc_sample,
   input  wire logic [11:0] dac_code,
   input  wire logic [11:0] ref_level,
   // Status.
   output logic [7:0]       setup_q,
   output logic [7:0]       conv_q,
   output logic [11:0]      result_q,
   output logic [3:0]       result_chan_q,
   output logic             result_valid_q,
   output logic             result_is_temp_q,
   output logic             temp_unread_q,
   output logic             osc_on_q,
   output logic             busy_q,
   output adcc_refcfg_t     refcfg_q,
   output logic [11:0]      dac_level_q
);
   localparam logic [4:0] TOP_CH = 5'(NUM_CH - 1);
   adcc_state_reg_t s_q, s_d;
   logic       sclk_fall, cs_rise, start_fall, byte_done, osc_req;
   logic [7:0] byte_in;
   logic [1:0] clk_mode;
   logic       skip;
   logic [3:0] ch4;

   function automatic logic pair_diff(adcc_state_reg_t s, logic [3:0] c);
      pair_diff = s.unipolar[c[3:1]] | s.bipolar[c[3:1]];
   endfunction

   always_comb begin
      s_d = s_q;
      s_d.sclk_sync  = {s_q.sclk_sync[1:0], sclk};
      s_d.cs_sync    = {s_q.cs_sync[0], cs_n};
      s_d.start_sync = {s_q.start_sync[1:0], conversion_start_pin_n};
      s_d.mosi_sync  = {s_q.mosi_sync[1:0], mosi};
      sclk_fall  = s_q.sclk_sync[2] & ~s_q.sclk_sync[1];
      cs_rise    = ~s_q.cs_sync[1] & s_d.cs_sync[1] & 1'b0;
      start_fall = s_q.start_sync[2] & ~s_q.start_sync[1];
      clk_mode   = s_q.setup[`ADCC_CLK_HI_BIT:`ADCC_CLK_LO_BIT];
      byte_done  = 1'b0;
      byte_in    = {s_q.shift[6:0], s_q.mosi_sync[2]};
      osc_req    = 1'b0;
      skip       = 1'b0;
      ch4        = s_q.chan[3:0];
      if (s_q.cs_sync[1]) begin
         s_d.bitcnt     = 4'h0;
         s_d.first_byte = 1'b1;
      end else if (sclk_fall) begin
         s_d.shift  = byte_in;
         s_d.bitcnt = s_q.bitcnt + 4'h1;
         if (s_q.bitcnt == 4'h7) begin
            byte_done  = 1'b1;
            s_d.bitcnt = 4'h0;
         end
      end
      if (byte_done) begin
         s_d.first_byte = 1'b0;
         if (s_q.data_left != 2'd0) begin
            // Data bytes after a GPIO command are absorbed.
            s_d.data_left = s_q.data_left - 2'd1;
         end else if (s_q.diff_target != 2'd0 && !s_q.first_byte) begin
            if (s_q.diff_target[0])
               s_d.unipolar = {s_q.unipolar[7:0], byte_in};
            else
               s_d.bipolar = {s_q.bipolar[7:0], byte_in};
         end else if (byte_in[`ADCC_CONV_BIT]) begin
            s_d.conv = byte_in;
            if (clk_mode[1] && s_q.state == ADCC_IDLE)
               osc_req = 1'b1;
         end else if (byte_in[`ADCC_SETUP_BIT]) begin
            s_d.setup = byte_in;
            s_d.diff_target = byte_in[`ADCC_DIFF_HI_BIT:`ADCC_DIFF_LO_BIT];
         end else if (byte_in[7:4] == 4'h0 && byte_in[3:0] != 4'h0) begin
            s_d.data_left = 2'(GPIO_BYTES);
         end
      end
      if (!clk_mode[1] && start_fall && s_q.state == ADCC_IDLE)
         osc_req = 1'b1;
      case (s_q.setup[`ADCC_REF_HI_BIT:`ADCC_REF_LO_BIT])
         2'b00:   s_d.refcfg = '{1'b1, 1'b0, 1'b0, 1'b1};
         2'b10:   s_d.refcfg = '{1'b1, 1'b0, 1'b1, 1'b1};
         2'b01:   s_d.refcfg = '{1'b0, 1'b0, 1'b1, 1'b0};
         default: s_d.refcfg = '{1'b0, 1'b1, 1'b1, 1'b0};
      endcase
      // Channel skip: start pin on the top channel, reference on the next.
      skip = (!clk_mode[1] && s_q.chan == TOP_CH) ||
             (!s_q.refcfg.second_reference_pin_is_input && s_q.chan == TOP_CH - 5'd1) ||
             (pair_diff(s_q, ch4) &&
              ((!clk_mode[1] && {ch4[3:1], 1'b1} == TOP_CH[3:0]) ||
               (!s_q.refcfg.second_reference_pin_is_input &&
                {ch4[3:1], 1'b0} == TOP_CH[3:0] - 4'd1)));
      s_d.osc_on = (clk_mode != 2'b11);
      if (s_q.timer != 8'd0 && clk_mode != 2'b11)
         s_d.timer = s_q.timer - 8'd1;
      else if (s_q.timer != 8'd0 && sclk_fall)
         s_d.timer = s_q.timer - 8'd1;
      s_d.result_valid = 1'b0;
      case (s_q.state)
         ADCC_IDLE: begin
            if (osc_req) begin
               s_d.timer = `ADCC_CONV_CYCLES;
               // A conversion byte taken this cycle must steer its own scan.
               case (adcc_scan_t'(s_d.conv[`ADCC_SCAN_MSB:`ADCC_SCAN_LSB]))
                  ADCC_SCAN_LOW: begin
                     s_d.chan = 5'd0;
                     s_d.last = {1'b0, s_d.conv[`ADCC_CH_MSB:`ADCC_CH_LSB]};
                  end
                  ADCC_SCAN_HIGH: begin
                     s_d.chan = {1'b0, s_d.conv[`ADCC_CH_MSB:`ADCC_CH_LSB]};
                     s_d.last = TOP_CH;
                  end
                  default: begin
                     s_d.chan = {1'b0, s_d.conv[`ADCC_CH_MSB:`ADCC_CH_LSB]};
                     s_d.last = s_d.chan;
                  end
               endcase
               s_d.reps = (s_d.conv[2:1] == 2'b10) ? 5'd16 : 5'd1;
               s_d.state = s_d.conv[`ADCC_TEMP_BIT] ? ADCC_TEMP_HI
                                                    : ADCC_CHAN;
               s_d.busy = 1'b1;
            end
         end
         ADCC_TEMP_HI: if (s_q.timer == 8'd0) begin
            s_d.temp_hi = adc_sample;
            s_d.timer = `ADCC_CONV_CYCLES;
            s_d.state = ADCC_TEMP_LO;
         end
         ADCC_TEMP_LO: if (s_q.timer == 8'd0) begin
            // Internal reference scaling gives eighth-degree steps.
            s_d.result = s_q.temp_hi - adc_sample - TEMP_OFFSET;
            s_d.result_is_temp = 1'b1;
            s_d.result_valid = 1'b1;
            s_d.temp_unread = 1'b1;
            s_d.timer = `ADCC_CONV_CYCLES;
            s_d.state = ADCC_CHAN;
         end
         ADCC_CHAN: if (s_q.timer == 8'd0) begin
            if (!skip) begin
               s_d.result = adc_sample;
               s_d.result_chan = pair_diff(s_q, ch4) ? {ch4[3:1], 1'b0}
                                                     : ch4;
               s_d.result_is_temp = 1'b0;
               s_d.result_valid = 1'b1;
            end
            s_d.timer = `ADCC_CONV_CYCLES;
            if (s_q.reps > 5'd1) begin
               s_d.reps = s_q.reps - 5'd1;
            end else if (s_q.chan >= s_q.last) begin
               s_d.state = ADCC_DONE;
            end else begin
               s_d.chan = (pair_diff(s_q, ch4) && !ch4[0]) ?
                          s_q.chan + 5'd2 : s_q.chan + 5'd1;
            end
         end
         ADCC_DONE: begin
            s_d.busy = 1'b0;
            s_d.timer = 8'd0;
            s_d.state = ADCC_IDLE;
         end
         default: s_d.state = ADCC_IDLE;
      endcase
      if (cs_rise)
         s_d.temp_unread = 1'b0;
      s_d.dac_level = 24'(({12'h0, dac_code} * {12'h0, ref_level}) >> 12);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q       <= '0;
         s_q.setup <= `ADCC_SETUP_RESET;
         s_q.conv  <= `ADCC_CONV_RESET;
         s_q.state <= ADCC_IDLE;
         s_q.sclk_sync  <= 3'b000;
         s_q.cs_sync    <= 2'b11;
         s_q.start_sync <= 3'b111;
      end else begin
         s_q <= s_d;
      end
   end

   assign setup_q          = s_q.setup;
   assign conv_q           = s_q.conv;
   assign result_q         = s_q.result;
   assign result_chan_q    = s_q.result_chan;
   assign result_valid_q   = s_q.result_valid;
   assign result_is_temp_q = s_q.result_is_temp;
   assign temp_unread_q    = s_q.temp_unread;
   assign osc_on_q         = s_q.osc_on;
   assign busy_q           = s_q.busy;
   assign refcfg_q         = s_q.refcfg;
   assign dac_level_q      = s_q.dac_level[11:0];
endmodule

// ---- core/adcc_defs.svh ----
// Constants for the converter command control block.
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
`define ADCC_CONV_BIT       7
`define ADCC_SETUP_BIT      6
`define ADCC_CLK_HI_BIT     5
`define ADCC_CLK_LO_BIT     4
`define ADCC_REF_HI_BIT     3
`define ADCC_REF_LO_BIT     2
`define ADCC_DIFF_HI_BIT    1
`define ADCC_DIFF_LO_BIT    0
`define ADCC_CH_MSB         6
`define ADCC_CH_LSB         3
`define ADCC_SCAN_MSB       2
`define ADCC_SCAN_LSB       1
`define ADCC_TEMP_BIT       0
`define ADCC_SETUP_RESET    8'h28
`define ADCC_CONV_RESET     8'h18
`define ADCC_DAC_FULL       13'h1000
`define ADCC_TEMP_OFFSET    12'h888
`define ADCC_CONV_CYCLES    8'd16
`endif

// ---- core/adcc_pkg.sv ----
// Types for the converter command control block.
package adcc_pkg;
   typedef enum logic [1:0] {
      ADCC_REF_INT, ADCC_REF_EXT, ADCC_REF_MIX, ADCC_REF_DIFF
   } adcc_ref_t;
   typedef enum logic [1:0] {
      ADCC_SCAN_LOW, ADCC_SCAN_HIGH, ADCC_SCAN_REPEAT, ADCC_SCAN_ONCE
   } adcc_scan_t;
   typedef enum {
      ADCC_IDLE, ADCC_TEMP_HI, ADCC_TEMP_LO, ADCC_CHAN, ADCC_DONE
   } adcc_state_t;
   typedef struct packed {
      logic       adc_int_ref;
      logic       adc_diff_ref;
      logic       dac_ext_ref;
      logic       second_reference_pin_is_input;
   } adcc_refcfg_t;
   typedef struct packed {
      logic [2:0]  sclk_sync;
      logic [1:0]  cs_sync;
      logic [2:0]  start_sync;
      logic [2:0]  mosi_sync;
      logic [7:0]  shift;
      logic [3:0]  bitcnt;
      logic        first_byte;
      logic [1:0]  data_left;
      logic [1:0]  diff_target;
      logic [7:0]  setup;
      logic [7:0]  conv;
      logic [15:0] unipolar;
      logic [15:0] bipolar;
      adcc_state_t state;
      logic [4:0]  chan;
      logic [4:0]  last;
      logic [4:0]  reps;
      logic [7:0]  timer;
      logic [11:0] temp_hi;
      logic [11:0] result;
      logic [3:0]  result_chan;
      logic        result_valid;
      logic        result_is_temp;
      logic        temp_unread;
      logic        osc_on;
      adcc_refcfg_t refcfg;
      logic        busy;
      logic [23:0] dac_level;
   } adcc_state_reg_t;
endpackage

// ---- tb/adcc_control_bench.sv ----
// Self-checking bench for the converter command control block.
`timescale 1ns/10ps
module adcc_control_bench;
   import adcc_pkg::*;
   logic         clk = 1'b0;
   logic         rst_n, start_n, sclk, cs_n, mosi;
   logic [11:0]  adc_sample, dac_code, ref_level, result_q, dac_level_q;
   logic [7:0]   setup_q, conv_q;
   logic [3:0]   result_chan_q;
   logic         result_valid_q, result_is_temp_q, temp_unread_q;
   logic         osc_on_q, busy_q;
   adcc_refcfg_t refcfg_q;
   int           num_errors, checks_done;
   logic [4:0]   got[$];
   logic [15:0]  tbl = 16'h4b29;
   always #12.5 clk = ~clk;
   adcc_host i_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
   adcc_control i_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk),
      .cs_n(cs_n), .mosi(mosi), .conversion_start_pin_n(start_n),
      .adc_sample(adc_sample), .dac_code(dac_code),
      .ref_level(ref_level), .setup_q(setup_q), .conv_q(conv_q),
      .result_q(result_q), .result_chan_q(result_chan_q),
      .result_valid_q(result_valid_q),
      .result_is_temp_q(result_is_temp_q),
      .temp_unread_q(temp_unread_q), .osc_on_q(osc_on_q),
      .busy_q(busy_q), .refcfg_q(refcfg_q), .dac_level_q(dac_level_q));
   // Records every result as temperature or channel number.
   always @(posedge clk) begin
      adc_sample <= adc_sample + 12'h001;
      if (result_valid_q === 1'b1)
         got.push_back(result_is_temp_q ? 5'h10 : {1'b0, result_chan_q});
   end
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task summarize;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task wr(input logic [7:0] b);
      i_host.send(b);
      repeat (8) @(posedge clk);
   endtask
   // Sends a conversion byte, optionally pulses the start pin, then
   // checks the number of results and the first and last of them.
   task run(input logic [7:0] b, input int n, input logic [4:0] f,
            input logic [4:0] l, input bit p);
      int k;
      got.delete();
      wr(b);
      repeat (40) @(posedge clk);
      if (p) begin
         start_n <= 1'b0;
         repeat (2) @(posedge clk);
         start_n <= 1'b1;
         repeat (8) @(posedge clk);
      end
      k = 0;
      while (busy_q !== 1'b0 && k < 2000) begin
         k++;
         @(posedge clk);
      end
      if (k == 2000) begin
         num_errors++;
         summarize();
      end
      chk("count", 16'(n), 16'(got.size()));
      if (n > 0) begin
         chk("first", 16'(f), 16'(got[0]));
         chk("last", 16'(l), 16'(got[$]));
      end
   endtask
   initial begin
      rst_n = 1'b0;
      start_n = 1'b1;
      adc_sample = 12'h000;
      dac_code = 12'h000;
      ref_level = 12'h000;
      num_errors = 0;
      checks_done = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      chk("setup", 16'h0028, 16'(setup_q));
      for (int k = 0; k < 4; k++) begin
         wr(8'h40 + 8'(k * 20));
         chk("setup", 16'h0040 + 16'(k * 20), 16'(setup_q));
         chk("osc", 16'(k != 3), 16'(osc_on_q));
         chk("refcfg", 16'(tbl[k*4 +: 4] & (k == 3 ? 4'hd : 4'hf)),
             16'(refcfg_q & (k == 3 ? 4'hd : 4'hf)));
      end
      wr(8'h68);
      run(8'h97, 2, 5'h10, 5'h02, 1'b0);
      chk("unread", 16'h0001, 16'(temp_unread_q));
      run(8'h98, 4, 5'h00, 5'h03, 1'b0);
      wr(8'h64);
      run(8'hea, 2, 5'h0d, 5'h0f, 1'b0);
      wr(8'h68);
      run(8'h84, 16, 5'h00, 5'h00, 1'b0);
      wr(8'h48);
      run(8'h86, 1, 5'h00, 5'h00, 1'b1);
      run(8'hfe, 0, 5'h00, 5'h00, 1'b1);
      for (int k = 0; k < 3; k++) begin
         dac_code <= k == 0 ? 12'hfff : (k == 1 ? 12'h800 : 12'h000);
         ref_level <= k == 1 ? 12'h800 : 12'hfff;
         repeat (4) @(posedge clk);
         chk("dac", k == 0 ? 16'h0ffe : (k == 1 ? 16'h0400 : 16'h0000),
             16'(dac_level_q));
      end
      wr(8'h02);
      wr(8'h98);
      wr(8'h98);
      chk("gpio", 16'h00fe, 16'(conv_q));
      summarize();
   end
endmodule
bind adcc_control adcc_control_props #(.NUM_CH(NUM_CH)) i_props (
   .clk(clk), .rst_n(rst_n), .conversion_start_pin_n(conversion_start_pin_n),
   .dac_code(dac_code), .ref_level(ref_level), .dac_level_q(dac_level_q),
   .setup_q(setup_q), .conv_q(conv_q), .result_chan_q(result_chan_q),
   .result_valid_q(result_valid_q), .result_is_temp_q(result_is_temp_q),
   .osc_on_q(osc_on_q), .busy_q(busy_q), .refcfg_q(refcfg_q));

// ---- tb/adcc_control_props.sv ----
// Assertions on the ports of the converter command control block.
`timescale 1ns/10ps
module adcc_control_props
   import adcc_pkg::*;
#(
   parameter int NUM_CH = 16
) (
   // Clock, reset and start pin.
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        conversion_start_pin_n,
   // Converter stand-ins.
   input wire logic [11:0] dac_code,
   input wire logic [11:0] ref_level,
   input wire logic [11:0] dac_level_q,
   // Status.
   input wire logic [7:0]  setup_q,
   input wire logic [7:0]  conv_q,
   input wire logic [3:0]  result_chan_q,
   input wire logic        result_valid_q,
   input wire logic        result_is_temp_q,
   input wire logic        osc_on_q,
   input wire logic        busy_q,
   input wire adcc_refcfg_t refcfg_q
);
   localparam logic [3:0] TOP  = 4'(NUM_CH - 1);
   localparam logic [3:0] SECOND_REFERENCE_PIN = 4'(NUM_CH - 2);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence cfg_s;
      $stable(setup_q) [*3];
   endsequence
   osc_mode_a: assert property (cfg_s |-> osc_on_q == (setup_q[5:4] != 2'b11))
      else $error("oscillator state does not follow clock mode");
   ref_cfg_a: assert property (cfg_s |-> refcfg_q.adc_int_ref == !setup_q[2]
      && refcfg_q.second_reference_pin_is_input == !setup_q[2]
      && refcfg_q.adc_diff_ref == (setup_q[3:2] == 2'b11))
      else $error("reference routing does not follow setup");
   dac_map_a: assert property (($stable(dac_code) && $stable(ref_level)) [*3]
      |-> dac_level_q == 12'((24'(dac_code) * 24'(ref_level)) >> 12))
      else $error("dac level is not code times reference over 4096");
   temp_first_a: assert property ($rose(busy_q) ##1 conv_q[0]
      |-> (!result_valid_q || result_is_temp_q) until_with result_valid_q)
      else $error("first result of a scan is not the temperature");
   temp_soon_a: assert property ($rose(busy_q) ##1
      (conv_q[0] && setup_q[5:4] != 2'b11) |-> ##[1:200] result_valid_q)
      else $error("temperature scan gave no result in time");
   start_pin_a: assert property ($fell(conversion_start_pin_n) && !busy_q
      && !setup_q[5] && conv_q[6:3] != TOP |-> ##[1:8] busy_q)
      else $error("start pin did not start a scan");
   valid_pulse_a: assert property (result_valid_q |=> !result_valid_q)
      else $error("result strobe longer than one cycle");
   skip_chan_a: assert property (result_valid_q && !result_is_temp_q
      |-> !(setup_q[2] && result_chan_q == SECOND_REFERENCE_PIN)
      && !(!setup_q[5] && result_chan_q == TOP))
      else $error("result from a channel that is not an input");
   single_chan_a: assert property (result_valid_q && !result_is_temp_q
      && conv_q[2] |-> result_chan_q == conv_q[6:3])
      else $error("repeat or single scan on wrong channel");
   scan_range_a: assert property (result_valid_q && !result_is_temp_q
      && !conv_q[2] |-> (conv_q[1] ? result_chan_q >= conv_q[6:3]
      : result_chan_q <= conv_q[6:3]))
      else $error("scan result outside selected range");
   temp_c: cover property (result_valid_q && result_is_temp_q);
   pin_c: cover property ($fell(conversion_start_pin_n) ##[1:8] busy_q);
   top_c: cover property (result_valid_q && result_chan_q == TOP);
endmodule

// ---- tb/adcc_host.sv ----
// Host serial master model that writes command bytes.
`timescale 1ns/10ps
module adcc_host (
   // Clock.
   input  wire logic clk,
   // Serial pins.
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi
);
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // Half period is four system clocks, so the serial clock runs at 5 MHz.
   // That rate is too fast for clock mode 11, which is never timed here.
   task automatic send(input logic [7:0] b);
      @(posedge clk);
      cs_n <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosi <= b[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
      end
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      mosi <= ~b[0];
   endtask
endmodule
